// >>> awm_alarm_warning_manager.sv
// Alarm, warning and over-travel manager with terminal readout and history.
// Assumes event inputs on clk_sys_i; pin inputs are asynchronous.
`timescale 1ns/100ps
`include "awm_defines.svh"

// What this block does
// [RQ1] Alarm opens driver-ready, servo-off; only reset clears, estop on release.
// [RQ2] Warning opens warning output; motor condition depends on the warning.
// [RQ3] Warnings clear by alarm-clear pin, clear command, or power cycle.
// [RQ4] Active limit opens its direction's output; party moves motor back out.
// [RQ5] Segment display shows fault codes only in mode zero, else I/O state.
// [RQ6] Status query lists each active fault, and nothing when none is active.
// [RQ7] Scroll key steps to next entry; quit key ends the session.
// [RQ8] Status list follows source index, not order of occurrence.
// [RQ9] History keeps at most 32 records.
// [RQ10] When full, oldest record drops and new one is appended.
// [RQ11] Readout numbers records newest first, newest being number 1.
// [RQ12] Record holds code, sub code, elapsed time and power-on count.
// [RQ13] Over-travel and emergency stop are never recorded.
// [RQ14] Undervoltage and RAM error never recorded; CPU/ROM by detail bit.
// [RQ15] Home reset by zero-set command or home return records event code.
// [RQ16] Outside party keeps power on just after a fault for recording.
// [RQ17] History readout opens with elapsed time and power-on count line.
// [RQ18] Status outputs stay closed normally and open only on abnormality.
// [RQ19] Any abnormality turns power LED orange; in mode zero the display names it.
// [RQ20] Each fault has its own flag, held until its own clear.
// [RQ21] History pointer starts newest, steps per scroll, ends after oldest.
module awm_alarm_warning_manager import awm_pkg::*; #(
	parameter int TICK_CYCLES = `AWM_TICK_MS * `AWM_CLK_MHZ * 1000
) (
	input wire logic clk_sys_i,
	input wire logic rst_i,
	input wire logic ce_i,
	input wire logic [3:0] reg_addr_i,
	input wire logic [7:0] reg_wdata_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	output logic [7:0] reg_rdata_o,
	input wire logic evt_valid_i,
	input wire logic [4:0] evt_index_i,
	input wire logic [7:0] evt_sub_i,
	input wire logic home_return_done_i,
	input wire logic emergency_stop_in_i,
	input wire logic alarm_clear_in_i,
	input wire logic hw_limit_plus_i,
	input wire logic hw_limit_minus_i,
	input wire logic soft_limit_plus_i,
	input wire logic soft_limit_minus_i,
	input wire logic [15:0] power_on_count_i,
	input wire logic [7:0] io_state_i,
	input wire logic status_monitor_query_i,
	input wire logic history_monitor_query_i,
	input wire logic scroll_key_i,
	input wire logic quit_key_i,
	output logic driver_ready_out_o,
	output logic warning_out_o,
	output logic overtravel_plus_out_o,
	output logic overtravel_minus_out_o,
	output logic servo_off_o,
	output logic servo_lock_o,
	output logic power_led_orange_o,
	output logic [7:0] seg_code_o,
	output logic seg_alarm_o,
	output logic term_valid_o,
	output logic [2:0] term_kind_o,
	output logic [5:0] term_number_o,
	output logic [7:0] term_code_o,
	output logic [7:0] term_sub_o,
	output logic [15:0] term_time_o,
	output logic [15:0] term_pwr_o,
	output logic term_busy_o
);

	// ****************************************************************
	// Pin synchronisers
	// ****************************************************************
	logic [3:0] pin_s1;
	logic [3:0] pin_s2;
	logic [3:0] pin_s3;
	logic [3:0] pin_q;
	logic clr_prev;
	logic estop;
	logic clr_rise;

	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			pin_s1 <= 4'h0;
			pin_s2 <= 4'h0;
			pin_s3 <= 4'h0;
		end else if (ce_i) begin
			pin_s1 <= {hw_limit_minus_i, hw_limit_plus_i,
				alarm_clear_in_i, emergency_stop_in_i};
			pin_s2 <= pin_s1;
			pin_s3 <= pin_s2;
		end
	end

	// A level counts once the second and third stages agree
	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			pin_q <= 4'h0;
			clr_prev <= 1'b0;
		end else if (ce_i) begin
			for (int i = 0; i < 4; i++) begin
				if (pin_s2[i] == pin_s3[i]) begin
					pin_q[i] <= pin_s3[i];
				end
			end
			clr_prev <= pin_q[1];
		end
	end

	assign estop = pin_q[0];
	assign clr_rise = pin_q[1] & ~clr_prev;

	// ****************************************************************
	// Register port
	// ****************************************************************
	logic disp_mode;
	logic cmd_wr;
	logic clear_cmd;
	logic absolute_zero_set_cmd;

	assign cmd_wr = reg_wr_i && (reg_addr_i == `AWM_REG_CMD);
	assign clear_cmd = cmd_wr && reg_wdata_i[`AWM_CMD_CLR_BIT];
	assign absolute_zero_set_cmd = cmd_wr && reg_wdata_i[`AWM_CMD_ZERO_BIT];

	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			disp_mode <= `AWM_CTRL_RST;
		end else if (ce_i && reg_wr_i && (reg_addr_i == `AWM_REG_CTRL)) begin
			disp_mode <= reg_wdata_i[`AWM_CTRL_MODE_BIT];
		end
	end

	// ****************************************************************
	// Fault flags
	// ****************************************************************
	logic [`AWM_NUM_FLAG-1:0] flags;
	logic warn_clear;
	logic any_alarm;
	logic any_warn;
	logic sw_ot;
	logic hw_ot;
	logic ot_plus;
	logic ot_minus;
	logic [`AWM_NUM_SRC-1:0] act_vec;

	assign warn_clear = clr_rise | clear_cmd; // [RQ3]

	// Set wins over clear; alarms only clear through reset
	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			flags <= '0; // [RQ1] [RQ3]
		end else if (ce_i) begin
			for (int i = 0; i < `AWM_NUM_FLAG; i++) begin
				flags[i] <= (evt_valid_i && (int'(evt_index_i) == i)) |
					(flags[i] & ~((i >= `AWM_FIRST_WARN) & warn_clear)); // [RQ20]
			end
		end
	end

	assign any_alarm = (|flags[`AWM_FIRST_WARN-1:0]) | estop; // [RQ1]
	assign any_warn = |flags[`AWM_NUM_FLAG-1:`AWM_FIRST_WARN]; // [RQ2]
	assign ot_plus = pin_q[2] | soft_limit_plus_i; // [RQ4]
	assign ot_minus = pin_q[3] | soft_limit_minus_i;
	assign sw_ot = soft_limit_plus_i | soft_limit_minus_i;
	assign hw_ot = pin_q[2] | pin_q[3];
	assign act_vec = {estop, hw_ot, sw_ot, flags}; // [RQ8]

	// ****************************************************************
	// Status outputs and display
	// ****************************************************************
	logic [5:0] disp_pick;

	assign disp_pick = awm_next_active(act_vec, 5'h00);

	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			driver_ready_out_o <= 1'b0;
			warning_out_o <= 1'b0;
			overtravel_plus_out_o <= 1'b0;
			overtravel_minus_out_o <= 1'b0;
			servo_off_o <= 1'b1;
			servo_lock_o <= 1'b0;
			power_led_orange_o <= 1'b0;
		end else if (ce_i) begin
			driver_ready_out_o <= ~any_alarm; // [RQ1] [RQ18]
			warning_out_o <= ~any_warn; // [RQ2] [RQ18]
			overtravel_plus_out_o <= ~ot_plus; // [RQ4] [RQ18]
			overtravel_minus_out_o <= ~ot_minus; // [RQ4] [RQ18]
			servo_off_o <= any_alarm | flags[`AWM_IDX_WOFF]; // [RQ1] [RQ2] [RQ14]
			servo_lock_o <= ot_plus | ot_minus;
			power_led_orange_o <= disp_pick[5]; // [RQ19]
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			seg_code_o <= 8'h00;
			seg_alarm_o <= 1'b0;
		end else if (ce_i) begin
			if ((disp_mode == `AWM_MODE_FAULT) && disp_pick[5]) begin
				seg_code_o <= awm_code_of(disp_pick[4:0]); // [RQ5] [RQ19]
				seg_alarm_o <= 1'b1;
			end else begin
				seg_code_o <= io_state_i; // [RQ5]
				seg_alarm_o <= 1'b0;
			end
		end
	end

	// ****************************************************************
	// Elapsed time since power-on
	// ****************************************************************
	logic [`AWM_TICK_W-1:0] tick_cnt;
	logic [`AWM_TIME_W-1:0] secs;

	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			tick_cnt <= '0;
			secs <= '0;
		end else if (ce_i) begin
			if (tick_cnt == `AWM_TICK_W'(TICK_CYCLES - 1)) begin
				tick_cnt <= '0;
				secs <= secs + 1'b1;
			end else begin
				tick_cnt <= tick_cnt + 1'b1;
			end
		end
	end

	// ****************************************************************
	// History recording
	// ****************************************************************
	awm_hist_if hist();
	logic rec_excl;
	logic rec_want;
	logic pend_home;
	logic [`AWM_HIST_AW-1:0] wr_ptr;
	logic [`AWM_CNT_W-1:0] hist_cnt;
	logic [`AWM_CNT_W-1:0] rd_num;

	// Undervoltage and RAM error never; CPU and ROM error by detail bit
	assign rec_excl = (evt_index_i == `AWM_IDX_P3) ||
		(evt_index_i == `AWM_IDX_E0) ||
		(((evt_index_i == `AWM_IDX_C3) || (evt_index_i == `AWM_IDX_E2)) &&
		!evt_sub_i[`AWM_SUB_REC_BIT]); // [RQ14]
	// Sources from 16 up are over-travel and estop, never recorded
	assign rec_want = evt_valid_i &&
		(int'(evt_index_i) < `AWM_NUM_FLAG) && !rec_excl; // [RQ13]

	// A home event waits while a fault record takes the write port
	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			pend_home <= 1'b0;
		end else if (ce_i) begin
			pend_home <= home_return_done_i | absolute_zero_set_cmd |
				(pend_home & rec_want); // [RQ15]
		end
	end

	always_comb begin
		hist.we = rec_want | pend_home;
		hist.waddr = wr_ptr;
		hist.wdata.time_s = secs; // [RQ12]
		hist.wdata.pwr_cnt = power_on_count_i;
		if (rec_want) begin
			hist.wdata.code = awm_code_of(evt_index_i); // [RQ12]
			hist.wdata.sub = evt_sub_i;
		end else begin
			hist.wdata.code = `AWM_CODE_HOME; // [RQ15]
			hist.wdata.sub = `AWM_SUB_NONE;
		end
		hist.raddr = wr_ptr - `AWM_HIST_AW'(1) - rd_num[`AWM_HIST_AW-1:0]; // [RQ11]
	end

	// Pointer wraps so the oldest record is overwritten once full
	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			wr_ptr <= '0;
			hist_cnt <= '0;
		end else if (ce_i && hist.we) begin
			wr_ptr <= wr_ptr + 1'b1; // [RQ10]
			if (hist_cnt != `AWM_CNT_W'(`AWM_HIST_DEPTH)) begin
				hist_cnt <= hist_cnt + 1'b1; // [RQ9]
			end
		end
	end

	awm_hist_mem u_mem (
		.clk_sys_i(clk_sys_i),
		.ce_i(ce_i),
		.hist(hist.mem)
	);

	// ****************************************************************
	// Terminal readout
	// ****************************************************************
	awm_state_t state;
	logic [4:0] cur;
	logic [5:0] first_pick;
	logic [5:0] step_pick;

	assign first_pick = awm_next_active(act_vec, 5'h00);
	assign step_pick = awm_next_active(act_vec, cur + 1'b1);
	assign term_busy_o = (state != AWM_S_IDLE);

	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			state <= AWM_S_IDLE;
			cur <= '0;
			rd_num <= '0;
			term_valid_o <= 1'b0;
			term_kind_o <= AWM_TK_NONE;
			term_number_o <= '0;
			term_code_o <= 8'h00;
			term_sub_o <= 8'h00;
			term_time_o <= 16'h0000;
			term_pwr_o <= 16'h0000;
		end else if (ce_i) begin
			term_valid_o <= 1'b0;
			case (state)
			AWM_S_IDLE: begin
				if (status_monitor_query_i) begin
					if (first_pick[5]) begin // [RQ6]
						cur <= first_pick[4:0];
						term_valid_o <= 1'b1;
						term_kind_o <= AWM_TK_STATUS;
						term_number_o <= '0;
						term_code_o <= awm_code_of(first_pick[4:0]);
						term_sub_o <= 8'h00;
						term_time_o <= 16'h0000;
						term_pwr_o <= 16'h0000;
						state <= AWM_S_STAT;
					end
				end else if (history_monitor_query_i) begin
					rd_num <= '0; // [RQ21]
					term_valid_o <= 1'b1;
					term_kind_o <= AWM_TK_HEADER; // [RQ17]
					term_number_o <= '0;
					term_code_o <= 8'h00;
					term_sub_o <= 8'h00;
					term_time_o <= secs;
					term_pwr_o <= power_on_count_i;
					state <= AWM_S_HIST;
				end
			end
			AWM_S_STAT: begin
				if (quit_key_i) begin
					term_valid_o <= 1'b1;
					term_kind_o <= AWM_TK_END; // [RQ7]
					state <= AWM_S_IDLE;
				end else if (scroll_key_i) begin
					term_valid_o <= 1'b1;
					if (step_pick[5] && (cur != `AWM_LAST_SRC)) begin
						cur <= step_pick[4:0]; // [RQ7] [RQ8]
						term_kind_o <= AWM_TK_STATUS;
						term_code_o <= awm_code_of(step_pick[4:0]);
					end else begin
						term_kind_o <= AWM_TK_END;
						state <= AWM_S_IDLE;
					end
				end
			end
			AWM_S_HIST: begin
				if (quit_key_i) begin
					term_valid_o <= 1'b1;
					term_kind_o <= AWM_TK_END; // [RQ7]
					state <= AWM_S_IDLE;
				end else if (scroll_key_i) begin
					if (rd_num < hist_cnt) begin
						state <= AWM_S_HREAD;
					end else begin
						term_valid_o <= 1'b1;
						term_kind_o <= AWM_TK_END; // [RQ21]
						state <= AWM_S_IDLE;
					end
				end
			end
			AWM_S_HREAD: begin
				term_valid_o <= 1'b1;
				term_kind_o <= AWM_TK_RECORD;
				term_number_o <= rd_num + 1'b1; // [RQ11]
				term_code_o <= hist.rdata.code; // [RQ12]
				term_sub_o <= hist.rdata.sub;
				term_time_o <= hist.rdata.time_s;
				term_pwr_o <= hist.rdata.pwr_cnt;
				rd_num <= rd_num + 1'b1; // [RQ21]
				state <= AWM_S_HIST;
			end
			default: begin
				state <= AWM_S_IDLE;
			end
			endcase
		end
	end

	// ****************************************************************
	// Register read
	// ****************************************************************
	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			reg_rdata_o <= 8'h00;
		end else if (ce_i) begin
			reg_rdata_o <= 8'h00;
			if (reg_rd_i) begin
				case (reg_addr_i)
				`AWM_REG_CTRL: reg_rdata_o <= {7'h00, disp_mode};
				`AWM_REG_STLO: reg_rdata_o <= flags[7:0];
				`AWM_REG_STHI: reg_rdata_o <= flags[15:8];
				`AWM_REG_MISC: reg_rdata_o <= {3'h0, estop, hw_ot, sw_ot,
					any_warn, any_alarm};
				`AWM_REG_HCNT: reg_rdata_o <= {2'h0, hist_cnt};
				default: reg_rdata_o <= 8'h00;
				endcase
			end
		end
	end

endmodule : awm_alarm_warning_manager

// >>> awm_defines.svh
// Constants of the alarm and warning manager: offsets, fields, counts, codes.
// Assumes inclusion by the package and the design files; holds definitions and nothing else.
`ifndef AWM_DEFINES_SVH
`define AWM_DEFINES_SVH

// ****************************************************************
// Clock and timing
// ****************************************************************
`define AWM_CLK_MHZ 200
`define AWM_TICK_MS 1000
`define AWM_TICK_W 32
`define AWM_TIME_W 16

// ****************************************************************
// Fault sources and history
// ****************************************************************
`define AWM_IDX_W 5
`define AWM_NUM_FLAG 16
`define AWM_NUM_SRC 19
`define AWM_LAST_SRC 5'd18
`define AWM_FIRST_WARN 14
`define AWM_IDX_C3 5'd6
`define AWM_IDX_E0 5'd8
`define AWM_IDX_E2 5'd9
`define AWM_IDX_P3 5'd13
`define AWM_IDX_WOFF 15
`define AWM_SUB_REC_BIT 7
`define AWM_HIST_DEPTH 32
`define AWM_HIST_AW 5
`define AWM_CNT_W 6
`define AWM_CODE_HOME 8'hee
`define AWM_SUB_NONE 8'h00
// Display codes of sources 18 down to 0 (F4 F3 F2 W1 W0 P3 E9..A0)
`define AWM_CODE_TABLE {8'hf4, 8'hf3, 8'hf2, 8'h51, 8'h50, 8'h73, \
	8'he9, 8'he8, 8'he7, 8'he2, 8'he0, 8'hc4, 8'hc3, 8'ha9, 8'ha7, \
	8'ha4, 8'ha2, 8'ha1, 8'ha0}

// ****************************************************************
// Register port
// ****************************************************************
`define AWM_REG_CTRL 4'h0
`define AWM_REG_CMD 4'h1
`define AWM_REG_STLO 4'h2
`define AWM_REG_STHI 4'h3
`define AWM_REG_MISC 4'h4
`define AWM_REG_HCNT 4'h5
`define AWM_CTRL_MODE_BIT 0
`define AWM_CMD_CLR_BIT 0
`define AWM_CMD_ZERO_BIT 1
`define AWM_MODE_FAULT 1'h0
`define AWM_CTRL_RST 1'h0

`endif

// >>> awm_pkg.sv
// Types and decode functions of the alarm and warning manager.
// Assumes awm_defines.svh is on the include path.
`include "awm_defines.svh"

package awm_pkg;

	typedef enum logic [1:0] {
		AWM_S_IDLE,
		AWM_S_STAT,
		AWM_S_HIST,
		AWM_S_HREAD
	} awm_state_t;

	typedef enum logic [2:0] {
		AWM_TK_NONE,
		AWM_TK_STATUS,
		AWM_TK_HEADER,
		AWM_TK_RECORD,
		AWM_TK_END
	} awm_term_kind_t;

	typedef struct packed {
		logic [7:0] code;
		logic [7:0] sub;
		logic [`AWM_TIME_W-1:0] time_s;
		logic [`AWM_TIME_W-1:0] pwr_cnt;
	} awm_rec_t;

	// Display code of one source index
	function automatic logic [7:0] awm_code_of(input logic [4:0] idx);
		logic [8*`AWM_NUM_SRC-1:0] tbl;
		tbl = `AWM_CODE_TABLE;
		awm_code_of = tbl[idx*8 +: 8];
	endfunction : awm_code_of

	// Lowest active source at or above from; bit 5 tells found
	function automatic logic [5:0] awm_next_active(
		input logic [`AWM_NUM_SRC-1:0] vec,
		input logic [4:0] from);
		logic found;
		logic [4:0] idx;
		found = 1'b0;
		idx = 5'h00;
		for (int i = 0; i < `AWM_NUM_SRC; i++) begin
			if (!found && vec[i] && (i >= int'(from))) begin
				found = 1'b1;
				idx = 5'(i);
			end
		end
		awm_next_active = {found, idx};
	endfunction : awm_next_active

endpackage : awm_pkg

// >>> awm_hist_if.sv
// Carrier between the manager and its history memory.
// Assumes one clock shared by both ends; no timing of its own.
`timescale 1ns/100ps
`include "awm_defines.svh"

interface awm_hist_if;
	import awm_pkg::*;
	logic we;
	logic [`AWM_HIST_AW-1:0] waddr;
	awm_rec_t wdata;
	logic [`AWM_HIST_AW-1:0] raddr;
	awm_rec_t rdata;
	modport ctrl(output we, output waddr, output wdata, output raddr,
		input rdata);
	modport mem(input we, input waddr, input wdata, input raddr,
		output rdata);
endinterface : awm_hist_if

// >>> awm_hist_mem.sv
// History memory: one write port, one read port with registered data.
// Assumes a single clock and an enable that freezes it when low.
`timescale 1ns/100ps
`include "awm_defines.svh"

module awm_hist_mem import awm_pkg::*; (
	input wire logic clk_sys_i,
	input wire logic ce_i,
	awm_hist_if.mem hist
);

	awm_rec_t mem [`AWM_HIST_DEPTH];

	always_ff @(posedge clk_sys_i) begin
		if (ce_i && hist.we) begin
			mem[hist.waddr] <= hist.wdata;
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (ce_i) begin
			hist.rdata <= mem[hist.raddr];
		end
	end

endmodule : awm_hist_mem

// >>> awm_mgr_props.sv
// Checker of the alarm and warning manager, bound to its top module.
// Assumes the top module's port names and one clock with sync reset.
`timescale 1ns/100ps

module awm_mgr_props (
	input wire logic clk_sys_i,
	input wire logic rst_i,
	input wire logic ce_i,
	input wire logic [3:0] reg_addr_i,
	input wire logic reg_rd_i,
	input wire logic [7:0] reg_rdata_o,
	input wire logic evt_valid_i,
	input wire logic [4:0] evt_index_i,
	input wire logic status_monitor_query_i,
	input wire logic scroll_key_i,
	input wire logic quit_key_i,
	input wire logic driver_ready_out_o,
	input wire logic warning_out_o,
	input wire logic overtravel_plus_out_o,
	input wire logic servo_off_o,
	input wire logic servo_lock_o,
	input wire logic power_led_orange_o,
	input wire logic seg_alarm_o,
	input wire logic term_valid_o,
	input wire logic [2:0] term_kind_o,
	input wire logic term_busy_o
);
	default clocking cb @(posedge clk_sys_i);
	endclocking
	default disable iff (rst_i);

	// ********
	// Fault outputs, history count and terminal
	// ********
	alarm_opens_ready_a: assert property (
		ce_i && evt_valid_i && evt_index_i < 5'd14 ##1 ce_i
		|=> !driver_ready_out_o) else $error("ready closed after alarm");
	alarm_servo_off_a: assert property (
		!driver_ready_out_o |-> servo_off_o)
		else $error("alarm without servo-off");
	warning_opens_a: assert property (
		ce_i && evt_valid_i && evt_index_i >= 5'd14 &&
		evt_index_i <= 5'd15 ##1 ce_i |=> !warning_out_o)
		else $error("warning output closed after warning");
	fault_led_a: assert property (
		!$past(rst_i) && !(driver_ready_out_o && warning_out_o)
		|-> power_led_orange_o) else $error("fault without orange led");
	limit_lock_a: assert property (
		!$past(rst_i) && !overtravel_plus_out_o |-> servo_lock_o)
		else $error("limit without servo-lock");
	seg_fault_a: assert property (
		seg_alarm_o |-> power_led_orange_o)
		else $error("fault code shown with no fault");
	hist_count_a: assert property (
		ce_i && reg_rd_i && reg_addr_i == 4'h5
		|=> reg_rdata_o <= 8'd32) else $error("history count above 32");
	status_line_a: assert property (
		ce_i && status_monitor_query_i && !term_busy_o &&
		power_led_orange_o |=> term_valid_o && term_kind_o == 3'd1)
		else $error("no status line for active fault");
	quit_ends_a: assert property (
		ce_i && quit_key_i && term_busy_o && !$past(scroll_key_i)
		|=> !term_busy_o) else $error("quit did not end session");
endmodule : awm_mgr_props

bind awm_alarm_warning_manager awm_mgr_props awm_mgr_props_i (.clk_sys_i,
	.rst_i, .ce_i, .reg_addr_i, .reg_rd_i, .reg_rdata_o, .evt_valid_i,
	.evt_index_i, .status_monitor_query_i, .scroll_key_i, .quit_key_i,
	.driver_ready_out_o, .warning_out_o, .overtravel_plus_out_o,
	.servo_off_o, .servo_lock_o, .power_led_orange_o, .seg_alarm_o,
	.term_valid_o, .term_kind_o, .term_busy_o);

// >>> awm_term_model.sv
// Operator terminal: presses query and key pulses, counts answer lines.
// Assumes answers come within a few cycles of each key.
`timescale 1ns/100ps

module awm_term_model (
	input wire logic clk_sys_i,
	input wire logic term_valid_i,
	output logic status_query_o,
	output logic history_query_o,
	output logic scroll_o,
	output logic quit_o
);
	int lines = 0;

	initial begin
		{status_query_o, history_query_o, scroll_o, quit_o} = 4'h0;
	end

	always @(posedge clk_sys_i) begin
		if (term_valid_i) begin
			lines <= lines + 1;
		end
	end

	// Key 0 status, 1 history, 2 scroll, 3 quit; one-cycle pulse
	task automatic press(input int k);
		@(posedge clk_sys_i);
		{status_query_o, history_query_o, scroll_o, quit_o} <= 4'h8 >> k;
		@(posedge clk_sys_i);
		{status_query_o, history_query_o, scroll_o, quit_o} <= 4'h0;
		repeat (5) @(posedge clk_sys_i);
		#1;
	endtask : press
endmodule : awm_term_model

// >>> tb_top.sv
// Self-checking bench of the alarm and warning manager.
// Assumes the design, its checker and the terminal model are compiled.
`timescale 1ns/100ps

module tb_top;
	logic clk_sys_i = 1'b0;
	logic rst_i = 1'b1;
	logic [3:0] reg_addr = 4'h0;
	logic [7:0] reg_wdata = 8'h00;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic evt_valid = 1'b0;
	logic [4:0] evt_index = 5'h00;
	logic [7:0] evt_sub = 8'h00;
	logic home_done = 1'b0;
	logic estop = 1'b0;
	logic clr_pin = 1'b0;
	logic ce = 1'b1;
	logic [7:0] io_st = 8'h5a;
	logic [15:0] pwr = 16'h0123;
	logic [3:0] lim = 4'h0;
	logic [7:0] reg_rdata, seg_code, tcode, tsub;
	logic sq, hq, scr, quit, tvalid, busy, seg_al;
	logic ready, warn, otp, otm, svoff, lock, orange;
	logic [2:0] tkind;
	logic [5:0] tnum;
	logic [15:0] ttime, tpwr;
	logic [6:0] st;
	logic [7:0] exp_st [3] = '{8'ha0, 8'hc3, 8'he0};
	int err_total = 0;
	int num_checks = 0;
	int cycles = 0;

	assign st = {ready, warn, otp, otm, svoff, lock, orange};
	always #2.5 clk_sys_i = ~clk_sys_i;

	awm_alarm_warning_manager #(.TICK_CYCLES(10)) awm_alarm_warning_manager_i (
		.clk_sys_i(clk_sys_i), .rst_i(rst_i), .ce_i(ce),
		.reg_addr_i(reg_addr), .reg_wdata_i(reg_wdata), .reg_wr_i(reg_wr),
		.reg_rd_i(reg_rd), .reg_rdata_o(reg_rdata), .evt_valid_i(evt_valid),
		.evt_index_i(evt_index), .evt_sub_i(evt_sub),
		.home_return_done_i(home_done), .emergency_stop_in_i(estop),
		.alarm_clear_in_i(clr_pin), .hw_limit_plus_i(lim[3]),
		.hw_limit_minus_i(lim[2]), .soft_limit_plus_i(lim[1]),
		.soft_limit_minus_i(lim[0]), .power_on_count_i(pwr),
		.io_state_i(io_st), .status_monitor_query_i(sq),
		.history_monitor_query_i(hq), .scroll_key_i(scr), .quit_key_i(quit),
		.driver_ready_out_o(ready), .warning_out_o(warn),
		.overtravel_plus_out_o(otp), .overtravel_minus_out_o(otm),
		.servo_off_o(svoff), .servo_lock_o(lock),
		.power_led_orange_o(orange), .seg_code_o(seg_code),
		.seg_alarm_o(seg_al), .term_valid_o(tvalid), .term_kind_o(tkind),
		.term_number_o(tnum), .term_code_o(tcode), .term_sub_o(tsub),
		.term_time_o(ttime), .term_pwr_o(tpwr), .term_busy_o(busy));

	awm_term_model awm_term_model_i (.clk_sys_i(clk_sys_i),
		.term_valid_i(tvalid), .status_query_o(sq), .history_query_o(hq),
		.scroll_o(scr), .quit_o(quit));

	// ********
	// Tasks
	// ********
	task automatic check(input string name, input logic [31:0] seen,
		input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			err_total++;
			$display("Error %s expected %h seen %h", name, exp, seen);
		end
	endtask : check

	task automatic step(input int n);
		repeat (n) @(posedge clk_sys_i);
		#1;
	endtask : step

	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge clk_sys_i);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk_sys_i);
		reg_wr <= 1'b0;
		step(2);
	endtask : wr

	task automatic rd(input logic [3:0] a, input logic [7:0] e);
		@(posedge clk_sys_i);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk_sys_i);
		reg_rd <= 1'b0;
		#1;
		check("reg_rdata", 32'(reg_rdata), 32'(e));
	endtask : rd

	task automatic evt(input logic [4:0] i, input logic [7:0] s);
		@(posedge clk_sys_i);
		evt_valid <= 1'b1;
		evt_index <= i;
		evt_sub <= s;
		@(posedge clk_sys_i);
		evt_valid <= 1'b0;
		step(2);
	endtask : evt

	task automatic finish_test;
		if (err_total == 0 && num_checks > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : finish_test

	always @(posedge clk_sys_i) begin
		cycles++;
		if (cycles == 6000) begin
			err_total++;
			finish_test();
		end
	end

	// ********
	// Sequence
	// ********
	initial begin
		step(12);
		rst_i <= 1'b0;
		step(2);
		check("status", 32'(st), 32'h78);
		rd(4'h0, 8'h00);
		rd(4'hf, 8'h00);
		awm_term_model_i.press(0);
		check("lines", 32'(awm_term_model_i.lines), 32'h0);
		evt(5'd14, 8'h00);
		check("status", 32'(st), 32'h59);
		check("seg", {23'h0, seg_al, seg_code}, 32'h150);
		wr(4'h0, 8'h01);
		check("seg", {23'h0, seg_al, seg_code}, 32'h05a);
		wr(4'h0, 8'h00);
		wr(4'h1, 8'h01);
		check("status", 32'(st), 32'h78);
		evt(5'd14, 8'h00);
		clr_pin <= 1'b1;
		step(7);
		clr_pin <= 1'b0;
		step(2);
		check("status", 32'(st), 32'h78);
		evt(5'd15, 8'h00);
		check("status", 32'(st), 32'h5d);
		wr(4'h1, 8'h01);
		lim <= 4'b0010;
		step(3);
		check("limits", {otp, otm, lock}, 32'h3);
		lim <= 4'b1100;
		step(7);
		check("limits", {otp, otm, lock}, 32'h1);
		lim <= 4'b0000;
		step(7);
		check("limits", {otp, otm, lock}, 32'h6);
		estop <= 1'b1;
		step(7);
		check("estop", {ready, svoff}, 32'h1);
		estop <= 1'b0;
		step(7);
		check("estop", {ready, svoff}, 32'h2);
		evt(5'd17, 8'h00);
		rd(4'h5, 8'd3);
		wr(4'h1, 8'h02);
		home_done <= 1'b1;
		step(1);
		home_done <= 1'b0;
		rd(4'h5, 8'd5);
		evt(5'd8, 8'h00);
		evt(5'd0, 8'h00);
		evt(5'd13, 8'h00);
		evt(5'd6, 8'h80);
		for (int i = 0; i < 3; i++) begin
			awm_term_model_i.press(i == 0 ? 0 : 2);
			check("status_code", {tkind, tcode}, {3'd1, exp_st[i]});
		end
		awm_term_model_i.press(3);
		check("busy", 32'(busy), 32'h0);
		wr(4'h1, 8'h01);
		check("alarm_held", {ready, svoff}, 32'h1);
		rd(4'h5, 8'd7);
		awm_term_model_i.press(1);
		check("header", {tkind, tpwr}, {3'd2, 16'h0123});
		check("hdr_time", 32'(ttime), 32'((cycles - 18) / 10));
		awm_term_model_i.press(2);
		check("rec1", {tkind, tnum, tcode, tsub}, {3'd3, 6'd1, 16'hc380});
		awm_term_model_i.press(2);
		check("rec2", {tkind, tnum, tcode}, {3'd3, 6'd2, 8'ha0});
		awm_term_model_i.press(3);
		repeat (29) evt(5'd1, 8'h00);
		evt(5'd2, 8'h00);
		rd(4'h5, 8'd32);
		awm_term_model_i.press(1);
		awm_term_model_i.press(2);
		check("newest", {tnum, tcode}, {6'd1, 8'ha2});
		repeat (31) awm_term_model_i.press(2);
		check("oldest", {tnum, tcode}, {6'd32, 8'ha0});
		awm_term_model_i.press(2);
		check("end", {tkind, busy}, {3'd4, 1'b0});
		// An event while the enable is low must not be taken
		ce <= 1'b0;
		evt(5'd14, 8'h00);
		ce <= 1'b1;
		step(2);
		check("ce_hold", 32'(warn), 32'h1);
		// Power stays up well past the last fault before cycling it
		step(20);
		rst_i <= 1'b1;
		step(4);
		rst_i <= 1'b0;
		step(2);
		check("power_cycle", 32'(st), 32'h78);
		finish_test();
	end
endmodule : tb_top
